// *** include/dac_ctrl_pkg.sv ***
// Shared constants and carrier types for the converter control-pin logic
package dac_ctrl_pkg;

	// ***********************************************************************
	// Timing
	// ***********************************************************************
	localparam int CLK_FREQ_MHZ = 100;
	// Clear sequence: busy stays low this long
	localparam int CLR_BUSY_TIME_US = 35;
	localparam int CLR_BUSY_CYCLES = CLR_BUSY_TIME_US * CLK_FREQ_MHZ;
	// Reset sequence: same length after power-on and after a reset pin edge
	localparam int RESET_BUSY_TIME_US = 270;
	localparam int RESET_BUSY_CYCLES = RESET_BUSY_TIME_US * CLK_FREQ_MHZ;
	// Corrected-code calculation length, in clock cycles
	localparam int CALC_BUSY_CYCLES = 16;
	// Sequence timer width, wide enough for the reset count
	localparam int TIMER_W = 16;

	// ***********************************************************************
	// Pin bundle, all pins from outside the clock domain
	// ***********************************************************************
	typedef struct packed {
		logic load_n;
		logic clear_n;
		logic reset_n;
		logic power_down;
		logic fifo_en;
		logic if_serial;
		logic proto_i2c;
		logic sclk;
		logic sdata;
	} pin_bundle_t;

	localparam int PIN_W = $bits(pin_bundle_t);
	// Idle pin levels taken by the synchroniser under reset
	localparam pin_bundle_t PIN_RESET_VAL = '{load_n: 1'b1, clear_n: 1'b1,
		reset_n: 1'b1, power_down: 1'b0, fifo_en: 1'b0, if_serial: 1'b0,
		proto_i2c: 1'b0, sclk: 1'b1, sdata: 1'b1};

	// Sequencer states
	typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_CALC, ST_CLEAR} seq_state_t;

endpackage : dac_ctrl_pkg

// *** core/pin_sync.sv ***
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ***********************************************************************
	// One chain per bit; first stage feeds only the second
	// ***********************************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_q;
			logic stable_q;
			// Both stages reset to the idle pin level
			always_ff @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					meta_q <= RESET_VAL[i];
					stable_q <= RESET_VAL[i];
				end
				else
				begin
					meta_q <= async_in[i];
					stable_q <= meta_q;
				end
			end
			assign sync_out[i] = stable_q;
		end
	endgenerate

endmodule : pin_sync

`default_nettype wire

// *** core/dac_update_control.sv ***
// Busy, load, clear, reset, power-down and interface-select pin logic
`timescale 1ns/1ns
`default_nettype none

module dac_update_control #(
	parameter int CALC_CYCLES = dac_ctrl_pkg::CALC_BUSY_CYCLES,
	parameter int RESET_CYCLES = dac_ctrl_pkg::RESET_BUSY_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_strobe_n_in,
	input wire logic preset_output_trigger_n_in,
	input wire logic reset_pin_n_in,
	input wire logic power_down_input_in,
	input wire logic fifo_enable_in,
	input wire logic interface_type_select_in,
	input wire logic serial_protocol_select_in,
	input wire logic shared_clock_pin_in,
	input wire logic shared_data_pin_in,
	input wire logic calc_start_in,
	input wire logic reg_write_in,
	input wire logic pd_mode_hiz_in,
	input wire logic i2c_sda_low_in,
	output logic busy_n_out,
	output logic interface_enable_out,
	output logic reg_write_accept_out,
	output logic converter_update_out,
	output logic preset_load_out,
	output logic register_default_out,
	output logic fifo_enabled_out,
	output logic analog_low_power_out,
	output logic output_hiz_out,
	output logic output_pulldown_out,
	output logic serial_mode_out,
	output logic spi_select_out,
	output logic i2c_select_out,
	output logic spi_shift_out,
	output logic serial_data_out,
	output logic i2c_scl_out,
	output logic shared_data_pin_out,
	output logic shared_data_pin_oe_out
);

	localparam int TW = dac_ctrl_pkg::TIMER_W;

	// ***********************************************************************
	// Pin synchronisation and edge detection
	// ***********************************************************************
	dac_ctrl_pkg::pin_bundle_t pins_raw;
	dac_ctrl_pkg::pin_bundle_t pins_s;
	logic [dac_ctrl_pkg::PIN_W-1:0] pins_sync;
	logic load_prev_q, clear_prev_q, reset_prev_q, sclk_prev_q;
	logic load_fall, clear_fall, reset_fall, sclk_fall;

	// Group the pins for a single synchroniser
	assign pins_raw = '{load_n: load_strobe_n_in, clear_n: preset_output_trigger_n_in,
		reset_n: reset_pin_n_in, power_down: power_down_input_in,
		fifo_en: fifo_enable_in, if_serial: interface_type_select_in,
		proto_i2c: serial_protocol_select_in, sclk: shared_clock_pin_in,
		sdata: shared_data_pin_in};

	pin_sync #(.WIDTH(dac_ctrl_pkg::PIN_W), .RESET_VAL(dac_ctrl_pkg::PIN_RESET_VAL)) u_pin_sync (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .async_in(pins_raw), .sync_out(pins_sync));
	assign pins_s = dac_ctrl_pkg::pin_bundle_t'(pins_sync);

	// Previous synchronised levels for edge finding
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			{load_prev_q, clear_prev_q, reset_prev_q, sclk_prev_q} <= 4'hf;
		else
		begin
			load_prev_q <= pins_s.load_n;
			clear_prev_q <= pins_s.clear_n;
			reset_prev_q <= pins_s.reset_n;
			sclk_prev_q <= pins_s.sclk;
		end
	end

	// Only falling edges act; a held-low reset pin does nothing more
	assign load_fall = load_prev_q & ~pins_s.load_n;
	assign clear_fall = clear_prev_q & ~pins_s.clear_n;
	assign reset_fall = reset_prev_q & ~pins_s.reset_n;
	assign sclk_fall = sclk_prev_q & ~pins_s.sclk;

	// ***********************************************************************
	// Busy sequencer
	// ***********************************************************************
	dac_ctrl_pkg::seq_state_t state_q, state_d;
	logic [TW-1:0] timer_q, timer_d;
	logic pending_q, seq_done, update_now;
	assign seq_done = (timer_q == '0);

	// Next state; reset edge beats everything, clear beats a calculation
	always_comb
	begin
		state_d = state_q;
		timer_d = (timer_q == '0) ? timer_q : timer_q - 1'b1;
		if (reset_fall)
		begin
			state_d = dac_ctrl_pkg::ST_RESET;
			timer_d = TW'(RESET_CYCLES - 1);
		end
		else
		begin
			case (state_q)
				dac_ctrl_pkg::ST_RESET, dac_ctrl_pkg::ST_CLEAR:
					if (seq_done)
						state_d = dac_ctrl_pkg::ST_IDLE;
				dac_ctrl_pkg::ST_IDLE, dac_ctrl_pkg::ST_CALC:
				begin
					if (clear_fall)
					begin
						state_d = dac_ctrl_pkg::ST_CLEAR;
						timer_d = TW'(dac_ctrl_pkg::CLR_BUSY_CYCLES - 1);
					end
					else if (state_q == dac_ctrl_pkg::ST_IDLE && calc_start_in)
					begin
						state_d = dac_ctrl_pkg::ST_CALC;
						timer_d = TW'(CALC_CYCLES - 1);
					end
					else if (state_q == dac_ctrl_pkg::ST_CALC && seq_done)
						state_d = dac_ctrl_pkg::ST_IDLE;
				end
				default:
					state_d = dac_ctrl_pkg::ST_RESET;
			endcase
		end
	end

	// Power-on reset runs the full reset sequence after release
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q <= dac_ctrl_pkg::ST_RESET;
			timer_q <= TW'(RESET_CYCLES - 1);
		end
		else
		begin
			state_q <= state_d;
			timer_q <= timer_d;
		end
	end

	// Load pending: stored while busy for a calculation or clear, dropped in reset
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pending_q <= 1'b0;
		else if (reset_fall || state_q == dac_ctrl_pkg::ST_RESET)
			pending_q <= 1'b0;
		else if (state_d == dac_ctrl_pkg::ST_IDLE && state_q != dac_ctrl_pkg::ST_IDLE)
			pending_q <= 1'b0; // Served on the busy rise
		else if (load_fall && (state_q != dac_ctrl_pkg::ST_IDLE
			|| state_d != dac_ctrl_pkg::ST_IDLE))
			pending_q <= 1'b1;
	end

	// Immediate load in idle, or a stored or coinciding one as busy returns high after a calculation or clear
	assign update_now = !reset_fall && state_d == dac_ctrl_pkg::ST_IDLE
		&& ((state_q == dac_ctrl_pkg::ST_IDLE && load_fall)
		|| (state_q != dac_ctrl_pkg::ST_IDLE && state_q != dac_ctrl_pkg::ST_RESET
		&& (pending_q || load_fall)));

	// ***********************************************************************
	// Sequencer outputs, all registered; busy and interface enable from the next state
	// ***********************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			busy_n_out <= 1'b0;
			interface_enable_out <= 1'b0;
			reg_write_accept_out <= 1'b0;
			converter_update_out <= 1'b0;
			preset_load_out <= 1'b0;
			register_default_out <= 1'b0;
		end
		else
		begin
			busy_n_out <= (state_d == dac_ctrl_pkg::ST_IDLE);
			interface_enable_out <= (state_d != dac_ctrl_pkg::ST_RESET);
			// Writes still land while a calculation runs
			reg_write_accept_out <= reg_write_in && state_q != dac_ctrl_pkg::ST_RESET;
			converter_update_out <= update_now;
			preset_load_out <= (state_q != dac_ctrl_pkg::ST_CLEAR
				&& state_d == dac_ctrl_pkg::ST_CLEAR);
			register_default_out <= reset_fall;
		end
	end

	// ***********************************************************************
	// FIFO enable sampling, power-down and serial interface select
	// ***********************************************************************
	// Sampled as a reset or clear sequence ends, so the pin is settled by then
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			fifo_enabled_out <= 1'b0;
		else if (state_q != dac_ctrl_pkg::ST_IDLE && state_q != dac_ctrl_pkg::ST_CALC
			&& state_d == dac_ctrl_pkg::ST_IDLE)
			fifo_enabled_out <= pins_s.fifo_en && !pins_s.if_serial;
		else if (pins_s.if_serial)
			fifo_enabled_out <= 1'b0;
	end

	// Power-down never gates the serial path
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			{analog_low_power_out, output_hiz_out, output_pulldown_out} <= 3'h0;
		else
		begin
			analog_low_power_out <= pins_s.power_down;
			output_hiz_out <= pins_s.power_down && pd_mode_hiz_in;
			output_pulldown_out <= pins_s.power_down && !pd_mode_hiz_in;
		end
	end

	// Serial pins; shifting needs clock below a third of clk_in
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			serial_mode_out <= 1'b0;
			spi_select_out <= 1'b0;
			i2c_select_out <= 1'b0;
			spi_shift_out <= 1'b0;
			serial_data_out <= 1'b1;
			i2c_scl_out <= 1'b1;
			shared_data_pin_out <= 1'b0;
			shared_data_pin_oe_out <= 1'b0;
		end
		else
		begin
			serial_mode_out <= pins_s.if_serial;
			spi_select_out <= pins_s.if_serial && !pins_s.proto_i2c;
			i2c_select_out <= pins_s.if_serial && pins_s.proto_i2c;
			spi_shift_out <= pins_s.if_serial && !pins_s.proto_i2c && sclk_fall
				&& state_q != dac_ctrl_pkg::ST_RESET;
			serial_data_out <= pins_s.sdata;
			i2c_scl_out <= pins_s.sclk;
			shared_data_pin_out <= 1'b0; // Open drain only pulls low
			shared_data_pin_oe_out <= pins_s.if_serial && pins_s.proto_i2c
				&& i2c_sda_low_in && state_q != dac_ctrl_pkg::ST_RESET;
		end
	end

	// ***********************************************************************
	// Checks
	// ***********************************************************************
	int seq_cnt_q;
	// Counts cycles spent in the current clear or reset sequence
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			seq_cnt_q <= 0;
		else if (state_d != state_q || reset_fall)
			seq_cnt_q <= 0;
		else
			seq_cnt_q <= seq_cnt_q + 1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_busy_calc: assert property ((state_q == dac_ctrl_pkg::ST_IDLE && calc_start_in
		&& !clear_fall && !reset_fall) |=> !busy_n_out [*2])
		else $error("busy not low during calculation");
	chk_no_update_busy: assert property (converter_update_out |-> busy_n_out)
		else $error("converter update while busy");
	chk_write_accept: assert property ((state_q == dac_ctrl_pkg::ST_CALC && reg_write_in)
		|=> reg_write_accept_out)
		else $error("write refused during calculation");
	chk_load_immediate: assert property ((state_q == dac_ctrl_pkg::ST_IDLE && load_fall
		&& !reset_fall && !clear_fall && !calc_start_in) |=> converter_update_out && busy_n_out)
		else $error("idle load not applied");
	chk_load_deferred: assert property ((state_q == dac_ctrl_pkg::ST_CALC && load_fall
		&& !reset_fall && !clear_fall && !seq_done) |=> pending_q)
		else $error("load during calculation lost");
	chk_pending_served: assert property ((pending_q && state_q == dac_ctrl_pkg::ST_CALC
		&& seq_done && !reset_fall && !clear_fall) |=> converter_update_out ##1 !pending_q)
		else $error("stored load not served");
	chk_reset_quiet: assert property (state_q == dac_ctrl_pkg::ST_RESET |=>
		!converter_update_out && !pending_q && !spi_shift_out)
		else $error("activity during reset");
	chk_clear_start: assert property ((clear_fall && !reset_fall
		&& state_q != dac_ctrl_pkg::ST_RESET && state_q != dac_ctrl_pkg::ST_CLEAR)
		|=> preset_load_out && !busy_n_out)
		else $error("clear not started");
	chk_clear_length: assert property ((state_q == dac_ctrl_pkg::ST_CLEAR
		&& state_d == dac_ctrl_pkg::ST_IDLE) |-> seq_cnt_q == dac_ctrl_pkg::CLR_BUSY_CYCLES - 1)
		else $error("clear busy length wrong");
	chk_reset_length: assert property ((state_q == dac_ctrl_pkg::ST_RESET
		&& state_d == dac_ctrl_pkg::ST_IDLE) |-> seq_cnt_q == RESET_CYCLES - 1
		##1 busy_n_out && interface_enable_out)
		else $error("reset busy length wrong");
	chk_reset_edge: assert property (reset_fall |=> !busy_n_out && !interface_enable_out
		&& register_default_out)
		else $error("reset edge not acted on");
	chk_fifo_parallel: assert property (fifo_enabled_out |-> !serial_mode_out)
		else $error("fifo enabled in serial mode");
	chk_sda_i2c_only: assert property (shared_data_pin_oe_out |-> i2c_select_out)
		else $error("data pin driven outside i2c");
	chk_spi_shift: assert property ((sclk_fall && pins_s.if_serial && !pins_s.proto_i2c
		&& state_q != dac_ctrl_pkg::ST_RESET) |=> spi_shift_out)
		else $error("spi falling edge missed");

	cov_deferred_load: cover property (pending_q ##1 converter_update_out);
	cov_clear_done: cover property ((seq_cnt_q == dac_ctrl_pkg::CLR_BUSY_CYCLES - 1)
		##1 $rose(busy_n_out));
	cov_reset_pin: cover property (reset_fall ##1 register_default_out);
	cov_pd_serial: cover property (analog_low_power_out && spi_shift_out);

endmodule : dac_update_control

`default_nettype wire

// *** bench/host_pins.sv ***
// Host-side model driving the strobe, reset and serial pins
`timescale 1ns/1ns
`default_nettype none

module host_pins (
	input wire logic clk_in,
	output logic load_n_out,
	output logic clear_n_out,
	output logic reset_n_out,
	output logic sclk_out,
	output logic sdata_out
);
	// ****************
	// Idle pin levels
	// ****************
	initial
	begin
		load_n_out = 1'b1;
		clear_n_out = 1'b1;
		reset_n_out = 1'b1;
		sclk_out = 1'b1;
		sdata_out = 1'b1;
	end

	// One pin changed just after a falling clock edge
	task automatic set_pin(input int idx, input logic lvl);
		@(negedge clk_in);
		case (idx)
			0: load_n_out = lvl;
			1: clear_n_out = lvl;
			2: reset_n_out = lvl;
			3: sclk_out = lvl;
			default: sdata_out = lvl;
		endcase
	endtask : set_pin

	// Four-cycle low pulse, long enough for the synchroniser
	task automatic pulse(input int idx);
		set_pin(idx, 1'b0);
		repeat (3) @(negedge clk_in);
		set_pin(idx, 1'b1);
	endtask : pulse

	// Byte sent MSB first at 160 ns per bit; data set half a period before the fall
	task automatic spi_send(input logic [7:0] val);
		for (int i = 7; i >= 0; i--)
		begin
			sdata_out = val[i];
			repeat (8) @(negedge clk_in);
			sclk_out = 1'b0;
			repeat (8) @(negedge clk_in);
			sclk_out = 1'b1;
		end
		// Clock stands high between frames; stale data is not left on the line
		sdata_out = ~val[0];
	endtask : spi_send
endmodule : host_pins
`default_nettype wire

// *** bench/dac_update_control_bench.sv ***
// Self-checking bench for the converter control-pin logic
`timescale 1ns/1ns
`default_nettype none

module dac_update_control_bench;
	localparam int CALC_N = 16;
	localparam int RST_N = 50;
	logic clk_in, rst_n_in, pwr_dn, fifo_en, if_ser, proto, calc, wr, hiz, sda_low;
	logic busy_n, if_en, wr_acc, upd, preset, dflt, fifo_on, lowp, ohiz, pull_dn;
	logic ser, spi, i2c, shift, sdat, scl_o, pin_o, oe;
	wire logic load_n, clear_n, reset_n, sclk, sdata_drv, sda_wire;
	logic [4:0] expq[$];
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;

	// Open-drain data wire: design pulls low, otherwise the host level
	assign sda_wire = oe ? pin_o : sdata_drv;

	host_pins host_pins_i (.clk_in(clk_in), .load_n_out(load_n), .clear_n_out(clear_n),
		.reset_n_out(reset_n), .sclk_out(sclk), .sdata_out(sdata_drv));

	dac_update_control #(.CALC_CYCLES(CALC_N), .RESET_CYCLES(RST_N)) dac_update_control_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .load_strobe_n_in(load_n),
		.preset_output_trigger_n_in(clear_n), .reset_pin_n_in(reset_n),
		.power_down_input_in(pwr_dn), .fifo_enable_in(fifo_en),
		.interface_type_select_in(if_ser), .serial_protocol_select_in(proto),
		.shared_clock_pin_in(sclk), .shared_data_pin_in(sda_wire), .calc_start_in(calc),
		.reg_write_in(wr), .pd_mode_hiz_in(hiz), .i2c_sda_low_in(sda_low),
		.busy_n_out(busy_n), .interface_enable_out(if_en), .reg_write_accept_out(wr_acc),
		.converter_update_out(upd), .preset_load_out(preset), .register_default_out(dflt),
		.fifo_enabled_out(fifo_on), .analog_low_power_out(lowp), .output_hiz_out(ohiz),
		.output_pulldown_out(pull_dn), .serial_mode_out(ser), .spi_select_out(spi),
		.i2c_select_out(i2c), .spi_shift_out(shift), .serial_data_out(sdat),
		.i2c_scl_out(scl_o), .shared_data_pin_out(pin_o), .shared_data_pin_oe_out(oe));

	// ****************
	// Shared tasks
	// ****************
	task automatic check_val(input string nm, input logic [15:0] ev, input logic [15:0] got);
		num_checks++;
		if (got !== ev)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, ev, got);
		end
	endtask : check_val

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc

	// Every noted pulse must have shown up by the end of a test
	task automatic done(input string nm);
		check_val("notes left", 16'h0, 16'(expq.size()));
		$display("test %s done", nm);
	endtask : done

	// Low time of busy, bounded so a stuck busy cannot hang the run
	task automatic count_busy(output int n);
		int w;
		w = 0;
		n = 0;
		while (busy_n !== 1'b0 && w < 10)
		begin
			@(negedge clk_in);
			w++;
		end
		while (busy_n === 1'b0 && n < 4000)
		begin
			@(negedge clk_in);
			n++;
		end
	endtask : count_busy

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// ****************
	// Clock, monitor, timeout
	// ****************
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Each pulse seen takes the oldest note; an unnoted pulse meets an empty note
	always @(negedge clk_in)
	begin
		logic [4:0] got, nt;
		got = {upd, preset, dflt, shift, shift & sdat};
		if (rst_n_in && (upd || preset || dflt || shift))
		begin
			nt = (expq.size() > 0) ? expq.pop_front() : 5'h00;
			check_val("pulse", nt, got);
			if (upd)
				check_val("busy at update", 1'b1, busy_n);
		end
	end

	// Ceiling well above the roughly 5100 cycles the tests take
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	// ****************
	// Test sequence
	// ****************
	initial
	begin
		int n;
		logic [7:0] b;
		rst_n_in = 1'b0;
		pwr_dn = 1'b0;
		fifo_en = 1'b0;
		if_ser = 1'b0;
		proto = 1'b0;
		calc = 1'b0;
		wr = 1'b0;
		hiz = 1'b0;
		sda_low = 1'b0;
		void'($urandom(32'h55130706));
		cyc(3);
		rst_n_in = 1'b1;
		// Power-on sequence drops a load strobe
		fork
			count_busy(n);
			begin
				cyc(5);
				check_val("if_en", 1'b0, if_en);
				b = 8'($urandom());
				wr = b[0];
				calc = b[1];
				@(negedge clk_in);
				wr = 1'b0;
				calc = 1'b0;
				check_val("wr_acc", 1'b0, wr_acc);
				host_pins_i.pulse(0);
			end
		join
		check_val("por busy", 16'(RST_N), 16'(n));
		cyc(8);
		check_val("if_en", 1'b1, if_en);
		check_val("serial", 1'b0, ser);
		done("power-on");
		// Load while idle, then load and write during a calculation
		expq.push_back(5'h10);
		host_pins_i.pulse(0);
		cyc(6);
		calc = 1'b1;
		@(negedge clk_in);
		calc = 1'b0;
		expq.push_back(5'h10);
		fork
			count_busy(n);
			begin
				wr = 1'b1;
				@(negedge clk_in);
				wr = 1'b0;
				check_val("wr_acc", 1'b1, wr_acc);
				host_pins_i.pulse(0);
			end
		join
		check_val("calc busy", 16'(CALC_N), 16'(n));
		cyc(4);
		done("load");
		// Clear with a random FIFO enable level
		b = 8'($urandom());
		fifo_en = b[0];
		expq.push_back(5'h08);
		fork
			count_busy(n);
			host_pins_i.pulse(1);
		join
		check_val("clear busy", 16'(dac_ctrl_pkg::CLR_BUSY_CYCLES), 16'(n));
		cyc(2);
		check_val("fifo", b[0], fifo_on);
		done("clear");
		// Reset pin held low past the end of its sequence
		expq.push_back(5'h04);
		fork
			count_busy(n);
			begin
				host_pins_i.set_pin(2, 1'b0);
				cyc(8);
				check_val("if_en", 1'b0, if_en);
				host_pins_i.pulse(0);
			end
		join
		check_val("reset busy", 16'(RST_N), 16'(n));
		cyc(20);
		check_val("busy", 1'b1, busy_n);
		host_pins_i.set_pin(2, 1'b1);
		done("reset pin");
		// Power-down in both output styles, random order
		b = 8'($urandom());
		for (int i = 0; i < 2; i++)
		begin
			hiz = b[0] ^ i[0];
			pwr_dn = 1'b1;
			cyc(4);
			check_val("low power", {lowp, ohiz, pull_dn}, {1'b1, hiz, ~hiz});
			pwr_dn = 1'b0;
			cyc(4);
			check_val("low power", 1'b0, lowp);
		end
		done("power-down");
		// SPI byte while powered down
		pwr_dn = 1'b1;
		fifo_en = 1'b0;
		if_ser = 1'b1;
		cyc(4);
		check_val("spi sel", 3'b110, {ser, spi, i2c});
		check_val("fifo", 1'b0, fifo_on);
		b = 8'($urandom());
		for (int i = 7; i >= 0; i--)
			expq.push_back({4'h1, b[i]});
		host_pins_i.spi_send(b);
		cyc(6);
		done("spi");
		// I2C: data pulled low at random, clock at both bus rates
		host_pins_i.set_pin(4, 1'b1);
		b = 8'($urandom());
		proto = 1'b1;
		sda_low = b[1];
		pwr_dn = b[2];
		cyc(4);
		check_val("i2c sel", 3'b101, {ser, spi, i2c});
		check_val("low power", b[2], lowp);
		check_val("sda drive", {b[1], 1'b0}, {oe, pin_o});
		cyc(3);
		check_val("sda in", !b[1], sdat);
		sda_low = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			host_pins_i.set_pin(3, 1'b0);
			cyc(5);
			check_val("scl", 1'b0, scl_o);
			cyc(i ? 120 : 495);
			host_pins_i.set_pin(3, 1'b1);
			cyc(5);
			check_val("scl", 1'b1, scl_o);
			cyc(i ? 120 : 495);
		end
		done("i2c");
		tally_and_finish();
	end
endmodule : dac_update_control_bench
`default_nettype wire
